// File: inc/rxcf_pkg.sv
// Shared constants and helpers for the receive checksum and filter control block.
package rxcf_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  RX_CONTROL_SECOND_OFS   = 8'h76;
    localparam logic [7:0]  TX_FREE_MEMORY_INFO_OFS = 8'h78;

    // ------------------------------------------------------------
    // Field layout of rx_control_second
    // ------------------------------------------------------------
    localparam int          BURST_LSB     = 5;
    localparam int          BURST_MSB     = 7;
    localparam int          FRAG_PASS_BIT = 4;
    localparam int          ZERO_ACC_BIT  = 3;
    localparam int          LITE_EN_BIT   = 2;
    localparam int          ICMP_EN_BIT   = 1;
    localparam int          SRC_FILT_BIT  = 0;
    localparam int          CTRL_W        = 5;
    localparam logic [4:0]  CTRL_RST      = 5'h04;
    localparam logic [2:0]  BURST_RST     = 3'h0;

    // ------------------------------------------------------------
    // Burst codes and transmit queue sizing
    // ------------------------------------------------------------
    localparam logic [2:0]  BURST_WHOLE   = 3'h4;
    localparam int          FREE_W        = 13;
    localparam logic [12:0] TXQ_BYTES_DEF = 13'h1000;
    localparam logic [12:0] CTRL_WORD_DEF = 13'h0004;

    typedef enum logic [1:0] {
        B_IDLE = 2'b01,
        B_RUN  = 2'b10
    } rxcf_burst_st_t;

    // Bytes per burst for codes 0 to 3; other codes run to the frame end.
    function automatic logic [5:0] burst_bytes(input logic [2:0] code);
        case (code)
            3'h0:    burst_bytes = 6'h04;
            3'h1:    burst_bytes = 6'h08;
            3'h2:    burst_bytes = 6'h10;
            3'h3:    burst_bytes = 6'h20;
            default: burst_bytes = 6'h00;
        endcase
    endfunction

    function automatic logic burst_whole(input logic [2:0] code);
        burst_whole = (code >= BURST_WHOLE);
    endfunction

    // Word-aligned decode of a byte address against a register offset.
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
        reg_hit = (addr[7:1] == ofs[7:1]);
    endfunction

endpackage

// File: inc/rxcf_link_if.sv
// Internal carrier between the register bank and its burst and memory helpers.
`timescale 1ns/10ps
interface rxcf_link_if;
    logic [2:0]                  burst_code;
    logic                        rxq_cmd;
    logic                        rxq_byte;
    logic                        rxq_frame_end;
    logic                        burst_done;
    logic                        burst_active;
    logic                        tx_alloc;
    logic [rxcf_pkg::FREE_W-1:0] tx_alloc_len;
    logic                        tx_release;
    logic [rxcf_pkg::FREE_W-1:0] tx_release_len;
    logic [rxcf_pkg::FREE_W-1:0] tx_free;

    modport top_mp (
        output burst_code, rxq_cmd, rxq_byte, rxq_frame_end,
        output tx_alloc, tx_alloc_len, tx_release, tx_release_len,
        input  burst_done, burst_active, tx_free
    );
    modport burst_mp (
        input  burst_code, rxq_cmd, rxq_byte, rxq_frame_end,
        output burst_done, burst_active
    );
    modport txmem_mp (
        input  tx_alloc, tx_alloc_len, tx_release, tx_release_len,
        output tx_free
    );
endinterface

// File: logic/rxcf_burst.sv
// Receive queue DMA burst tracker.
`timescale 1ns/10ps
module rxcf_burst (
    // Clock and reset
    input wire logic     sys_clk,
    input wire logic     rst,
    // Link to the register bank
    rxcf_link_if.burst_mp lnk
);
    rxcf_pkg::rxcf_burst_st_t st_ff;
    logic [5:0]               cnt_ff;
    logic                     done_ff;
    logic [5:0]               len;
    logic                     last;

    assign len  = rxcf_pkg::burst_bytes(lnk.burst_code);
    assign last = lnk.rxq_frame_end ||
                  (!rxcf_pkg::burst_whole(lnk.burst_code) && cnt_ff == len - 6'h01);

    // A burst only starts on a read command byte; stray bytes are ignored.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_ff  <= rxcf_pkg::B_IDLE;
            cnt_ff <= 6'h00;
        end else begin
            case (st_ff)
                rxcf_pkg::B_IDLE: begin
                    if (lnk.rxq_cmd) begin
                        st_ff  <= rxcf_pkg::B_RUN;
                        cnt_ff <= 6'h00;
                    end
                end
                rxcf_pkg::B_RUN: begin
                    if (lnk.rxq_byte) begin
                        if (last) begin
                            st_ff <= rxcf_pkg::B_IDLE;
                        end
                        cnt_ff <= cnt_ff + 6'h01;
                    end
                end
                default: st_ff <= rxcf_pkg::B_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= (st_ff == rxcf_pkg::B_RUN) && lnk.rxq_byte && last;
        end
    end

    assign lnk.burst_done   = done_ff;
    assign lnk.burst_active = (st_ff == rxcf_pkg::B_RUN);

    chk_burst_ends_count: assert property (@(posedge sys_clk) disable iff (rst)
        st_ff == rxcf_pkg::B_RUN && lnk.rxq_byte && !lnk.rxq_frame_end && lnk.burst_code == 3'h0
        && cnt_ff == 6'h03 |=> done_ff && st_ff == rxcf_pkg::B_IDLE)
        else $error("Four byte burst did not end on its fourth byte.");

    chk_burst_needs_cmd: assert property (@(posedge sys_clk) disable iff (rst)
        st_ff == rxcf_pkg::B_IDLE && !lnk.rxq_cmd |=> st_ff == rxcf_pkg::B_IDLE && !done_ff)
        else $error("Burst began without a read command byte.");
endmodule

// File: logic/rxcf_txmem.sv
// Free byte counter of the transmit queue.
`timescale 1ns/10ps
module rxcf_txmem #(
    parameter logic [rxcf_pkg::FREE_W-1:0] TXQ_BYTES = rxcf_pkg::TXQ_BYTES_DEF,
    parameter logic [rxcf_pkg::FREE_W-1:0] CTRL_WORD = rxcf_pkg::CTRL_WORD_DEF
) (
    // Clock and reset
    input wire logic      sys_clk,
    input wire logic      rst,
    // Link to the register bank
    rxcf_link_if.txmem_mp lnk
);
    logic [rxcf_pkg::FREE_W-1:0] free_ff;
    logic [rxcf_pkg::FREE_W-1:0] take;
    logic [rxcf_pkg::FREE_W-1:0] give;

    // Each frame also holds a control word, so it is charged and refunded too.
    assign take = lnk.tx_alloc   ? lnk.tx_alloc_len + CTRL_WORD : '0;
    assign give = lnk.tx_release ? lnk.tx_release_len + CTRL_WORD : '0;

    // An allocate and a release in one cycle both count; neither is lost.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            free_ff <= TXQ_BYTES;
        end else begin
            free_ff <= free_ff + give - take;
        end
    end

    assign lnk.tx_free = free_ff;

    chk_free_charges_ctrl: assert property (@(posedge sys_clk) disable iff (rst)
        lnk.tx_alloc && !lnk.tx_release |=>
        free_ff == $past(free_ff) - $past(lnk.tx_alloc_len) - CTRL_WORD)
        else $error("Allocation did not charge payload plus control word.");
endmodule

// File: logic/rxcf_regs.sv
// Receive checksum, source filter and transmit memory control registers.
//
// Function
// - Burst length sits in bits 7..5, write-only, reset zero; bits 15..8 reserved.
// - Burst codes give 4, 8, 16, 32 bytes or a whole frame; others reserved.
// - Fragment-pass bit lets fragmented UDP frames pass the checksum check.
// - Zero-checksum bit accepts UDP frames with zero checksum; clear drops them.
// - UDP-Lite bit enables receive checking and transmit generation; resets set.
// - ICMP bit drops non-fragmented ICMP frames with a wrong checksum.
// - Source filter bit drops frames whose source equals the station address.
// - Transmit memory register reports free queue bytes in bits 12..0.
// - Free count charges both payload bytes and each frame's control word.
// - Station address is one 48-bit value for all comparisons.
`timescale 1ns/10ps
module rxcf_regs #(
    parameter logic [rxcf_pkg::FREE_W-1:0] TXQ_BYTES = rxcf_pkg::TXQ_BYTES_DEF,
    parameter logic [rxcf_pkg::FREE_W-1:0] CTRL_WORD = rxcf_pkg::CTRL_WORD_DEF
) (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    // Register port from the serial host interface
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [1:0]                  reg_be,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    input  wire logic [15:0]                 reg_wdata,
    output logic      [15:0]                 reg_rdata,
    output logic                             reg_rack,
    // Station address
    input  wire logic [47:0]                 station_addr,
    // Received frame classification
    input  wire logic                        frm_valid,
    input  wire logic [47:0]                 frm_src_addr,
    input  wire logic                        frm_is_udp,
    input  wire logic                        frm_is_udp_lite,
    input  wire logic                        frm_is_icmp,
    input  wire logic                        frm_frag,
    input  wire logic                        frm_csum_zero,
    input  wire logic                        frm_csum_bad,
    output logic                             frm_done,
    output logic                             frm_drop,
    // Transmit side
    output logic                             udp_lite_tx_gen,
    input  wire logic                        tx_alloc,
    input  wire logic [rxcf_pkg::FREE_W-1:0] tx_alloc_len,
    input  wire logic                        tx_release,
    input  wire logic [rxcf_pkg::FREE_W-1:0] tx_release_len,
    output logic      [rxcf_pkg::FREE_W-1:0] tx_free_bytes,
    // Receive queue DMA
    input  wire logic                        rxq_cmd,
    input  wire logic                        rxq_byte,
    input  wire logic                        rxq_frame_end,
    output logic                             rxq_burst_done,
    output logic                             rxq_burst_active
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [rxcf_pkg::CTRL_W-1:0] ctrl_ff;
    logic [2:0]                  burst_ff;
    logic [15:0]                 rdata_ff;
    logic                        rack_ff;
    logic                        done_ff;
    logic                        drop_ff;
    logic [15:0]                 nxt_rdata;
    logic                        nxt_drop;

    logic frag_pass;
    logic zero_accept;
    logic lite_en;
    logic icmp_en;
    logic src_filt;
    logic wr_ctrl;

    rxcf_link_if lnk ();

    assign frag_pass   = ctrl_ff[rxcf_pkg::FRAG_PASS_BIT];
    assign zero_accept = ctrl_ff[rxcf_pkg::ZERO_ACC_BIT];
    assign lite_en     = ctrl_ff[rxcf_pkg::LITE_EN_BIT];
    assign icmp_en     = ctrl_ff[rxcf_pkg::ICMP_EN_BIT];
    assign src_filt    = ctrl_ff[rxcf_pkg::SRC_FILT_BIT];

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Every control bit lives in the low byte, so only that lane matters.
    assign wr_ctrl = reg_wr && reg_be[0] && rxcf_pkg::reg_hit(reg_addr, rxcf_pkg::RX_CONTROL_SECOND_OFS);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_ff <= rxcf_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_ff <= reg_wdata[rxcf_pkg::CTRL_W-1:0];
        end
    end

    // A reserved burst code is stored as written; the tracker then runs to the frame end.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            burst_ff <= rxcf_pkg::BURST_RST;
        end else if (wr_ctrl) begin
            burst_ff <= reg_wdata[rxcf_pkg::BURST_MSB:rxcf_pkg::BURST_LSB];
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    always_comb begin
        nxt_rdata = 16'h0000;
        if (rxcf_pkg::reg_hit(reg_addr, rxcf_pkg::RX_CONTROL_SECOND_OFS)) begin
            nxt_rdata[rxcf_pkg::CTRL_W-1:0] = ctrl_ff;
        end else if (rxcf_pkg::reg_hit(reg_addr, rxcf_pkg::TX_FREE_MEMORY_INFO_OFS)) begin
            nxt_rdata[rxcf_pkg::FREE_W-1:0] = lnk.tx_free;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_ff <= 16'h0000;
            rack_ff  <= 1'b0;
        end else begin
            rack_ff <= reg_rd;
            if (reg_rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign reg_rdata = rdata_ff;
    assign reg_rack  = rack_ff;

    // ------------------------------------------------------------
    // Receive frame verdict
    // ------------------------------------------------------------
    // The whole 48-bit station address is compared in one step.
    always_comb begin
        nxt_drop = 1'b0;
        if (src_filt && frm_src_addr == station_addr) begin
            nxt_drop = 1'b1;
        end
        if (frm_is_udp && frm_csum_zero && !zero_accept) begin
            nxt_drop = 1'b1;
        end
        if (frm_is_udp && !frm_csum_zero && frm_csum_bad && !(frm_frag && frag_pass)) begin
            nxt_drop = 1'b1;
        end
        if (frm_is_udp_lite && lite_en && frm_csum_bad && !(frm_frag && frag_pass)) begin
            nxt_drop = 1'b1;
        end
        if (frm_is_icmp && !frm_frag && icmp_en && frm_csum_bad) begin
            nxt_drop = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            done_ff <= 1'b0;
            drop_ff <= 1'b0;
        end else begin
            done_ff <= frm_valid;
            drop_ff <= frm_valid && nxt_drop;
        end
    end

    assign frm_done        = done_ff;
    assign frm_drop        = drop_ff;
    assign udp_lite_tx_gen = lite_en;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // The host is trusted to check free space before writing a frame.
    assign lnk.burst_code     = burst_ff;
    assign lnk.rxq_cmd        = rxq_cmd;
    assign lnk.rxq_byte       = rxq_byte;
    assign lnk.rxq_frame_end  = rxq_frame_end;
    assign lnk.tx_alloc       = tx_alloc;
    assign lnk.tx_alloc_len   = tx_alloc_len;
    assign lnk.tx_release     = tx_release;
    assign lnk.tx_release_len = tx_release_len;
    assign rxq_burst_done     = lnk.burst_done;
    assign rxq_burst_active   = lnk.burst_active;
    assign tx_free_bytes      = lnk.tx_free;

    rxcf_burst u_burst (
        .sys_clk (sys_clk),
        .rst     (rst),
        .lnk     (lnk.burst_mp)
    );

    rxcf_txmem #(
        .TXQ_BYTES (TXQ_BYTES),
        .CTRL_WORD (CTRL_WORD)
    ) u_txmem (
        .sys_clk (sys_clk),
        .rst     (rst),
        .lnk     (lnk.txmem_mp)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_ctrl_read_zero: assert property (@(posedge sys_clk) disable iff (rst)
        reg_rd && rxcf_pkg::reg_hit(reg_addr, rxcf_pkg::RX_CONTROL_SECOND_OFS) |=>
        reg_rack && reg_rdata[15:5] == 11'h000 && reg_rdata[4:0] == $past(ctrl_ff))
        else $error("Control register read showed write-only or reserved bits.");

    chk_ctrl_write_keep: assert property (@(posedge sys_clk) disable iff (rst)
        wr_ctrl |=> ctrl_ff == $past(reg_wdata[4:0]) && burst_ff == $past(reg_wdata[7:5]))
        else $error("Control write did not store its low byte fields.");

    chk_free_read: assert property (@(posedge sys_clk) disable iff (rst)
        reg_rd && rxcf_pkg::reg_hit(reg_addr, rxcf_pkg::TX_FREE_MEMORY_INFO_OFS) |=>
        reg_rdata[15:13] == 3'h0 && reg_rdata[12:0] == $past(lnk.tx_free))
        else $error("Free memory read did not show the free count.");

    chk_src_filter_drop: assert property (@(posedge sys_clk) disable iff (rst)
        frm_valid && src_filt && frm_src_addr == station_addr |=> frm_done && frm_drop)
        else $error("Frame from own station address was not dropped.");

    chk_zero_csum_drop: assert property (@(posedge sys_clk) disable iff (rst)
        frm_valid && frm_is_udp && frm_csum_zero && !frm_is_udp_lite && !frm_is_icmp |=>
        frm_drop == (!$past(zero_accept) || $past(src_filt && frm_src_addr == station_addr)))
        else $error("Zero checksum UDP verdict did not follow its control bit.");

    chk_icmp_bad_drop: assert property (@(posedge sys_clk) disable iff (rst)
        frm_valid && frm_is_icmp && !frm_frag && icmp_en && frm_csum_bad |=> frm_drop)
        else $error("Bad ICMP checksum frame was not dropped.");

    chk_lite_off_pass: assert property (@(posedge sys_clk) disable iff (rst)
        frm_valid && frm_is_udp_lite && !frm_is_udp && !frm_is_icmp && !lite_en
        && !(src_filt && frm_src_addr == station_addr) |=> frm_done && !frm_drop)
        else $error("UDP-Lite frame dropped while its checking was off.");

    chk_frag_pass: assert property (@(posedge sys_clk) disable iff (rst)
        frm_valid && frm_is_udp && !frm_is_udp_lite && !frm_is_icmp && frm_frag && frag_pass
        && !frm_csum_zero && !(src_filt && frm_src_addr == station_addr) |=> !frm_drop)
        else $error("Fragmented UDP frame failed checksum despite fragment pass.");

endmodule

// File: test/rxcf_host_model.sv
// Host side model that issues register accesses to the control block.
`timescale 1ns/10ps
module rxcf_host_model (
    // Clock
    input  wire logic        sys_clk,
    // Register port towards the block
    output logic      [7:0]  reg_addr,
    output logic      [1:0]  reg_be,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rack
);
    initial begin
        reg_addr  = 8'h00;
        reg_be    = 2'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 16'h0000;
    end

    // Released lines flip, so a stale address or data word is never taken for a fresh one.
    task automatic release_bus();
        reg_addr  = ~reg_addr;
        reg_wdata = ~reg_wdata;
        reg_be    = ~reg_be;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [1:0] be, input logic [15:0] data);
        @(posedge sys_clk);
        #1;
        reg_addr  = addr;
        reg_be    = be;
        reg_wdata = data;
        reg_wr    = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_wr = 1'b0;
        release_bus();
    endtask

    task automatic rd(input logic [7:0] addr, output logic [15:0] data, output logic ok);
        @(posedge sys_clk);
        #1;
        reg_addr = addr;
        reg_rd   = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_rd = 1'b0;
        release_bus();
        ok   = 1'b0;
        data = 16'h0000;
        for (int i = 0; i < 3 && !ok; i++) begin
            if (reg_rack === 1'b1) begin
                data = reg_rdata;
                ok   = 1'b1;
            end else begin
                @(posedge sys_clk);
                #1;
            end
        end
    endtask
endmodule

// File: test/test_rx_checksum_filter_control.sv
// Self-checking testbench of the receive checksum and filter control registers.
`timescale 1ns/10ps
module test_rx_checksum_filter_control;
    localparam logic [12:0] TXQ_BYTES = 13'h0040;
    localparam logic [12:0] CTRL_WORD = 13'h0004;
    localparam logic [47:0] STATION   = 48'h0a1b2c3d4e5f;
    logic        sys_clk, rst, reg_wr, reg_rd, reg_rack, frm_valid, frm_done, frm_drop, udp_lite_tx_gen;
    logic        frm_is_udp, frm_is_udp_lite, frm_is_icmp, frm_frag, frm_csum_zero, frm_csum_bad;
    logic        tx_alloc, tx_release, rxq_cmd, rxq_byte, rxq_frame_end, rxq_burst_done, rxq_burst_active;
    logic [7:0]  reg_addr;
    logic [1:0]  reg_be;
    logic [15:0] reg_wdata, reg_rdata;
    logic [47:0] station_addr, frm_src_addr;
    logic [12:0] tx_alloc_len, tx_release_len, tx_free_bytes;
    int          n_fail, samples_checked;

    rxcf_regs #(.TXQ_BYTES(TXQ_BYTES), .CTRL_WORD(CTRL_WORD)) i_rxcf_regs (
        .sys_clk, .rst, .reg_addr, .reg_be, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rack,
        .station_addr, .frm_valid, .frm_src_addr, .frm_is_udp, .frm_is_udp_lite, .frm_is_icmp,
        .frm_frag, .frm_csum_zero, .frm_csum_bad, .frm_done, .frm_drop, .udp_lite_tx_gen,
        .tx_alloc, .tx_alloc_len, .tx_release, .tx_release_len, .tx_free_bytes,
        .rxq_cmd, .rxq_byte, .rxq_frame_end, .rxq_burst_done, .rxq_burst_active
    );
    rxcf_host_model i_rxcf_host_model (
        .sys_clk, .reg_addr, .reg_be, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rack
    );

    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic rd_check(input logic [7:0] addr, input logic [15:0] exp);
        logic [15:0] data;
        logic        ok;
        i_rxcf_host_model.rd(addr, data, ok);
        check({15'h0, ok}, 16'h0001, "read answer");
        check(data, exp, "read data");
    endtask

    task automatic stop_test();
        $display("Checks made %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    function automatic logic exp_drop(input logic [4:0] c, input logic [5:0] f);
        logic udp, lite, icmp, frag, zero, bad;
        udp  = (f[1:0] == 2'h0);
        lite = (f[1:0] == 2'h1);
        icmp = (f[1:0] == 2'h2);
        frag = f[2];
        zero = f[3];
        bad  = f[4];
        exp_drop = (c[0] & f[5]) | (udp & zero & !c[3]) | (udp & !zero & bad & !(frag & c[4]))
                 | (lite & c[2] & bad & !(frag & c[4])) | (icmp & !frag & c[1] & bad);
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        rd_check(rxcf_pkg::RX_CONTROL_SECOND_OFS, 16'h0004);
        rd_check(rxcf_pkg::TX_FREE_MEMORY_INFO_OFS, {3'h0, TXQ_BYTES});
        rd_check(8'h7a, 16'h0000);
        check({15'h0, udp_lite_tx_gen}, 16'h0001, "lite generate at reset");
        $display("Test reset done");
    endtask

    task automatic test_access();
        i_rxcf_host_model.wr(8'h76, 2'h1, 16'hfff7);
        rd_check(8'h76, 16'h0017);
        i_rxcf_host_model.wr(8'h76, 2'h2, 16'h0000);
        rd_check(8'h76, 16'h0017);
        i_rxcf_host_model.wr(8'h78, 2'h3, 16'h0000);
        rd_check(8'h78, {3'h0, TXQ_BYTES});
        i_rxcf_host_model.wr(8'h76, 2'h1, 16'h0000);
        check({15'h0, udp_lite_tx_gen}, 16'h0000, "lite generate off");
        $display("Test access done");
    endtask

    task automatic test_verdict();
        for (int c = 0; c < 32; c++) begin
            i_rxcf_host_model.wr(8'h76, 2'h1, {11'h0, c[4:0]});
            for (int f = 0; f < 64; f++) begin
                @(posedge sys_clk);
                #1;
                frm_valid       = 1'b1;
                {frm_is_icmp, frm_is_udp_lite, frm_is_udp} = {f[1:0] == 2'h2, f[1:0] == 2'h1, f[1:0] == 2'h0};
                {frm_csum_bad, frm_csum_zero, frm_frag} = f[4:2];
                frm_src_addr    = f[5] ? STATION : STATION ^ {c[0], 46'h0, ~c[0]};
                @(posedge sys_clk);
                #1;
                frm_valid = 1'b0;
                if (frm_done !== 1'b1) begin
                    @(posedge sys_clk);
                    #1;
                end
                check({15'h0, frm_done}, 16'h0001, "verdict given");
                check({15'h0, frm_drop}, {15'h0, exp_drop(c[4:0], f[5:0])}, "drop");
            end
        end
        $display("Test verdict done");
    endtask

    task automatic tx_step(input logic a, input logic [12:0] al, input logic r, input logic [12:0] rl,
                           input logic [12:0] exp);
        logic [15:0] data;
        logic        ok;
        i_rxcf_host_model.rd(8'h78, data, ok);
        check({15'h0, !a || data[12:0] >= al + CTRL_WORD}, 16'h0001, "room before write");
        @(posedge sys_clk);
        #1;
        {tx_alloc, tx_alloc_len, tx_release, tx_release_len} = {a, al, r, rl};
        @(posedge sys_clk);
        #1;
        {tx_alloc, tx_release} = 2'b00;
        check({3'h0, tx_free_bytes}, {3'h0, exp}, "free bytes");
        rd_check(8'h78, {3'h0, exp});
    endtask

    task automatic test_txmem();
        tx_step(1'b1, 13'd20, 1'b0, 13'd0, TXQ_BYTES - 13'd24);
        tx_step(1'b1, 13'd10, 1'b1, 13'd20, TXQ_BYTES - 13'd14);
        tx_step(1'b0, 13'd0, 1'b1, 13'd10, TXQ_BYTES);
        $display("Test transmit memory done");
    endtask

    task automatic test_burst();
        logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h3};
        int         flen [7]  = '{99, 99, 99, 99, 10, 5, 7};
        int         exp [7]   = '{4, 8, 16, 32, 10, 5, 7};
        int         n;
        for (int k = 0; k < 7; k++) begin
            i_rxcf_host_model.wr(8'h76, 2'h1, {8'h0, codes[k], 5'h1b});
            rd_check(8'h76, 16'h001b);
            @(posedge sys_clk);
            #1;
            rxq_byte = 1'b1;
            @(posedge sys_clk);
            #1;
            rxq_byte = 1'b0;
            rxq_cmd  = 1'b1;
            check({15'h0, rxq_burst_active}, 16'h0000, "idle byte ignored");
            @(posedge sys_clk);
            #1;
            rxq_cmd = 1'b0;
            check({15'h0, rxq_burst_active}, 16'h0001, "burst started");
            n = 0;
            while (rxq_burst_done !== 1'b1 && n < 40) begin
                rxq_byte      = 1'b1;
                rxq_frame_end = (n + 1 == flen[k]);
                @(posedge sys_clk);
                #1;
                n++;
            end
            rxq_byte      = 1'b0;
            rxq_frame_end = 1'b0;
            check(n[15:0], exp[k][15:0], "burst bytes");
            check({15'h0, rxq_burst_active}, 16'h0000, "burst ended");
        end
        $display("Test burst done");
    endtask

    initial begin
        #(40000 * 25);
        check(16'h0000, 16'h0001, "watchdog");
        stop_test();
    end

    initial begin
        n_fail          = 0;
        samples_checked = 0;
        rst             = 1'b1;
        station_addr    = STATION;
        {frm_valid, frm_is_udp, frm_is_udp_lite, frm_is_icmp} = 4'h0;
        {frm_frag, frm_csum_zero, frm_csum_bad} = 3'h0;
        frm_src_addr    = 48'h0;
        {tx_alloc, tx_release, tx_alloc_len, tx_release_len} = 28'h0;
        {rxq_cmd, rxq_byte, rxq_frame_end} = 3'h0;
        repeat (3) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        test_reset();
        test_access();
        test_verdict();
        test_txmem();
        test_burst();
        // A second reset in mid-run must bring every register back to its reset value.
        @(posedge sys_clk);
        #1;
        rst = 1'b1;
        @(posedge sys_clk);
        #1;
        rst = 1'b0;
        test_reset();
        stop_test();
    end
endmodule
